// ===== src/ppio_core.sv
/*
 * Programmable parallel I/O core: three 8-bit ports, a control word,
 * port C single-bit set/reset and the interrupt mask flip-flops.
 * Assumes CPU strobes synchronous to mclk; handshake sequencing of the
 * strobed modes lives outside and arrives as request levels.
 */
module ppio_core (
	input  wire logic       mclk,                // System clock, 100 MHz.
	input  wire logic       resetn,              // Sync reset, active low.
	input  wire logic       cs_n,                // Chip select, active low.
	input  wire logic       rd_n,                // Read strobe, active low.
	input  wire logic       wr_n,                // Write strobe, active low.
	input  wire logic       port_select_lsb,     // Register index bit 0.
	input  wire logic       port_select_msb,     // Register index bit 1.
	input  wire logic [7:0] bus_lines_i,         // Data bus from the CPU.
	output logic      [7:0] bus_lines_o,         // Data bus to the CPU.
	output logic            bus_lines_oe_n,      // Bus drive, active low.
	input  wire logic [7:0] first_port_lines_i,  // Port A pin levels.
	output logic      [7:0] first_port_lines_o,  // Port A latch.
	output logic      [7:0] first_port_lines_oe_n, // Port A drive, low.
	input  wire logic [7:0] second_port_lines_i, // Port B pin levels.
	output logic      [7:0] second_port_lines_o, // Port B latch.
	output logic      [7:0] second_port_lines_oe_n, // Port B drive, low.
	input  wire logic [7:0] third_port_lines_i,  // Port C pin levels.
	output logic      [7:0] third_port_lines_o,  // Port C latch.
	output logic      [7:0] third_port_lines_oe_n, // Port C drive, low.
	input  wire logic       hs_req_a_in,         // Group A input request.
	input  wire logic       hs_req_a_out,        // Group A output request.
	input  wire logic       hs_req_b,            // Group B request.
	output logic            irq_a,               // Gated group A interrupt.
	output logic            irq_b,               // Gated group B interrupt.
	output logic      [2:0] irq_mask_ff          // Mask flip-flop states.
);
	import ppio_pkg::*;

	ppio_bus_if bus ();

	// Control word and output latches.
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [7:0] a_latch;
	logic [7:0] next_a_latch;
	logic [7:0] b_latch;
	logic [7:0] next_b_latch;
	logic [7:0] c_latch;
	logic [7:0] next_c_latch;
	logic [2:0] mask;
	logic [2:0] next_mask;
	// Read data and interrupt outputs.
	logic [7:0] rd_data;
	logic [7:0] next_rd_data;
	logic       irq_a_q;
	logic       next_irq_a;
	logic       irq_b_q;
	logic       next_irq_b;
	// Decoded configuration.
	ppio_mode_t mode_a;
	ppio_mode_t mode_b;
	logic       a_in;
	logic       b_in;
	logic       cu_in;
	logic       cl_in;
	logic       wr_ctrl;
	logic       mode_def;
	logic       bsr_cmd;
	logic [2:0] bsr_pos;

	// Strobe decoder.
	ppio_bus_dec u_dec (
		.mclk   (mclk),
		.resetn (resetn),
		.cs_n   (cs_n),
		.rd_n   (rd_n),
		.wr_n   (wr_n),
		.sel    ({port_select_msb, port_select_lsb}),
		.data   (bus_lines_i),
		.bus    (bus.dec)
	);

	// Configuration fields of the current control word; each group reads
	// only its own bits, so the two modes are independent.
	assign mode_a = ppio_mode_a(ctrl);
	assign mode_b = ppio_mode_b(ctrl);
	assign a_in   = ctrl[A_DIR_BIT];
	assign cu_in  = ctrl[CU_DIR_BIT];
	assign b_in   = ctrl[B_DIR_BIT];
	assign cl_in  = ctrl[CL_DIR_BIT];

	// Kind of control write: bit 7 splits mode definition from set/reset.
	assign wr_ctrl  = bus.wr_pulse && (bus.sel == OFF_CTRL);
	assign mode_def = wr_ctrl && bus.wdata[MODE_FLAG_BIT];
	assign bsr_cmd  = wr_ctrl && !bus.wdata[MODE_FLAG_BIT];
	assign bsr_pos  = bus.wdata[BSR_SEL_HI:BSR_SEL_LO];

	// Next control word: a mode definition takes effect from one write.
	always_comb begin
		next_ctrl = ctrl;
		if (mode_def) begin
			next_ctrl = bus.wdata;
		end
	end

	// Next port latches. A mode definition clears them all, which also
	// clears the handshake status levels that sit on port C.
	always_comb begin
		next_a_latch = a_latch;
		next_b_latch = b_latch;
		next_c_latch = c_latch;
		if (mode_def) begin
			next_a_latch = LATCH_RESET;
			next_b_latch = LATCH_RESET;
			next_c_latch = LATCH_RESET;
		end else if (bsr_cmd) begin
			// Any bit, whether data or handshake, as if it were output.
			next_c_latch[bsr_pos] = bus.wdata[BSR_VAL_BIT];
		end else if (bus.wr_pulse) begin
			case (bus.sel)
				OFF_PORT_A: next_a_latch = bus.wdata;
				OFF_PORT_B: next_b_latch = bus.wdata;
				OFF_PORT_C: next_c_latch = bus.wdata;
				default:    next_c_latch = c_latch;
			endcase
		end
	end

	// Next mask flip-flops: set/reset of the steering bit in a strobed or
	// bidirectional group, cleared by every mode definition.
	always_comb begin
		next_mask = mask;
		if (mode_def) begin
			next_mask = MASK_RESET;
		end else if (bsr_cmd) begin
			if (mode_a != MODE_BASIC && bsr_pos == MASK_A_IN_POS) begin
				next_mask[MASK_A_IN] = bus.wdata[BSR_VAL_BIT];
			end
			if (mode_a != MODE_BASIC && bsr_pos == MASK_A_OUT_POS) begin
				next_mask[MASK_A_OUT] = bus.wdata[BSR_VAL_BIT];
			end
			if (mode_b != MODE_BASIC && bsr_pos == MASK_B_POS) begin
				next_mask[MASK_B] = bus.wdata[BSR_VAL_BIT];
			end
		end
	end

	// Next read data. Input ports and all of port C show live pins; the
	// control word always reads with bit 7 set.
	always_comb begin
		case (bus.sel)
			OFF_PORT_A: next_rd_data = (a_in || mode_a == MODE_BIDIR) ?
				first_port_lines_i : a_latch;
			OFF_PORT_B: next_rd_data = b_in ?
				second_port_lines_i : b_latch;
			OFF_PORT_C: next_rd_data = third_port_lines_i;
			OFF_CTRL:   next_rd_data = ctrl | 8'h80;
			default:    next_rd_data = 8'h00;
		endcase
	end

	// Next interrupt outputs: each request passes through its mask while its group is not in basic mode.
	always_comb begin
		next_irq_a = (mode_a != MODE_BASIC) &&
			((mask[MASK_A_IN] && hs_req_a_in) ||
			(mask[MASK_A_OUT] && hs_req_a_out));
		next_irq_b = (mode_b != MODE_BASIC) &&
			mask[MASK_B] && hs_req_b;
	end

	// State registers; reset restores the all-input configuration.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ctrl    <= CTRL_RESET;
			a_latch <= LATCH_RESET;
			b_latch <= LATCH_RESET;
			c_latch <= LATCH_RESET;
			mask    <= MASK_RESET;
			rd_data <= LATCH_RESET;
			irq_a_q <= IRQ_RESET;
			irq_b_q <= IRQ_RESET;
		end else begin
			ctrl    <= next_ctrl;
			a_latch <= next_a_latch;
			b_latch <= next_b_latch;
			c_latch <= next_c_latch;
			mask    <= next_mask;
			rd_data <= next_rd_data;
			irq_a_q <= next_irq_a;
			irq_b_q <= next_irq_b;
		end
	end

	// Data bus drive: only during a qualified read.
	assign bus_lines_o    = rd_data;
	assign bus_lines_oe_n = !bus.rd_active;

	// Port pins: latches drive whenever the direction bit says output.
	// Port A in bidirectional mode waits for handshake logic to drive it.
	assign first_port_lines_o  = a_latch;
	assign second_port_lines_o = b_latch;
	assign third_port_lines_o  = c_latch;
	assign first_port_lines_oe_n  =
		{8{a_in || mode_a == MODE_BIDIR}};
	assign second_port_lines_oe_n = {8{b_in}};
	assign third_port_lines_oe_n  = {{4{cu_in}}, {4{cl_in}}};

	assign irq_a       = irq_a_q;
	assign irq_b       = irq_b_q;
	assign irq_mask_ff = mask;

	// Checks on the behaviour above.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	a_read_port_b: assert property (
		bus.rd_active && bus.sel == OFF_PORT_B && !b_in ##1
		$stable(b_latch) |-> bus_lines_o == b_latch)
	else $error("port B latch not returned on read");

	a_write_port_a: assert property (
		bus.wr_pulse && bus.sel == OFF_PORT_A |=>
		a_latch == $past(bus_lines_i))
	else $error("port A write not loaded");

	a_bus_float: assert property (
		(cs_n || (rd_n && wr_n) || !wr_n) |-> bus_lines_oe_n)
	else $error("data bus driven outside a read");

	a_reset_ctrl: assert property (@(posedge mclk)
		disable iff (1'b0) // Reset itself is what this check watches.
		!resetn ##1 resetn |-> ctrl == CTRL_RESET &&
		first_port_lines_oe_n == 8'hFF &&
		third_port_lines_oe_n == 8'hFF)
	else $error("reset did not restore all-input control");

	a_ctrl_readback: assert property (
		bus.rd_active && bus.sel == OFF_CTRL |=>
		bus_lines_o[7] && bus_lines_o[6:0] == $past(ctrl[6:0]))
	else $error("control readback wrong");

	a_mode_clears: assert property (
		mode_def |=> a_latch == 8'h00 && b_latch == 8'h00 &&
		c_latch == 8'h00 && mask == 3'h0 &&
		ctrl == $past(bus_lines_i))
	else $error("mode write did not clear outputs and masks");

	a_bsr_one_bit: assert property (
		bsr_cmd |=> c_latch[$past(bsr_pos)] == $past(bus_lines_i[0]) &&
		ctrl == $past(ctrl) &&
		(c_latch ^ $past(c_latch)) == (($past(c_latch) ^
		({8{$past(bus_lines_i[0])}})) & (8'h01 << $past(bsr_pos))))
	else $error("set/reset disturbed other bits or mode");

	a_live_input: assert property (
		bus.rd_active && bus.sel == OFF_PORT_A && a_in &&
		mode_a == MODE_BASIC |=> bus_lines_o == $past(first_port_lines_i))
	else $error("input read not live");

	a_dir_enables: assert property (
		mode_a == MODE_BASIC |-> first_port_lines_oe_n == {8{a_in}} &&
		second_port_lines_oe_n == {8{b_in}} &&
		third_port_lines_oe_n[7:4] == {4{cu_in}} &&
		third_port_lines_oe_n[3:0] == {4{cl_in}})
	else $error("direction enables do not follow control word");

	a_irq_gate: assert property (
		!mask[MASK_B] |=> !irq_b)
	else $error("group B interrupt passed a clear mask");

	// Reads, writes and interrupt gating seen from the bus side.
	a_bus_drive: assert property (
		!cs_n && !rd_n && wr_n |-> !bus_lines_oe_n)
	else $error("data bus not driven during a read");

	a_read_latch_a: assert property (
		bus.rd_active && bus.sel == OFF_PORT_A && !a_in &&
		mode_a != MODE_BIDIR |=> bus_lines_o == $past(a_latch))
	else $error("port A latch not returned on read");

	a_read_port_c: assert property (
		bus.rd_active && bus.sel == OFF_PORT_C |=>
		bus_lines_o == $past(third_port_lines_i))
	else $error("port C read did not sample the pins");

	a_live_input_b: assert property (
		bus.rd_active && bus.sel == OFF_PORT_B && b_in |=>
		bus_lines_o == $past(second_port_lines_i))
	else $error("port B input read not live");

	a_write_port_b: assert property (
		bus.wr_pulse && bus.sel == OFF_PORT_B |=>
		b_latch == $past(bus_lines_i))
	else $error("port B write not loaded");

	a_write_port_c: assert property (
		bus.wr_pulse && bus.sel == OFF_PORT_C |=>
		c_latch == $past(bus_lines_i))
	else $error("port C write not loaded");

	a_write_once: assert property (
		bus.wr_pulse |=> !bus.wr_pulse)
	else $error("held write strobe loaded twice");

	a_port_write_mode: assert property (
		bus.wr_pulse && bus.sel != OFF_CTRL |=> ctrl == $past(ctrl))
	else $error("port write disturbed the control word");

	a_latch_hold_a: assert property (
		!bus.wr_pulse |=> a_latch == $past(a_latch))
	else $error("port A latch changed without a write");

	a_mask_steer_b: assert property (
		bsr_cmd && mode_b != MODE_BASIC && bsr_pos == MASK_B_POS |=>
		mask[MASK_B] == $past(bus_lines_i[BSR_VAL_BIT]))
	else $error("group B mask not set by set/reset");

	a_irq_gate_a: assert property (
		!mask[MASK_A_IN] && !mask[MASK_A_OUT] |=> !irq_a)
	else $error("group A interrupt passed clear masks");

	a_irq_pass_b: assert property (
		mode_b != MODE_BASIC && mask[MASK_B] && hs_req_b |=> irq_b)
	else $error("group B interrupt blocked by a set mask");

endmodule : ppio_core

// ===== src/ppio_pkg.sv
/*
 * Shared constants and types for the programmable parallel I/O core.
 * Assumes an 8-bit CPU bus whose two port-select lines pick one of four
 * registers, and a single 100 MHz clock for the whole block.
 */
package ppio_pkg;

	// Register indices on the two port-select lines.
	localparam logic [1:0] OFF_PORT_A = 2'h0;
	localparam logic [1:0] OFF_PORT_B = 2'h1;
	localparam logic [1:0] OFF_PORT_C = 2'h2;
	localparam logic [1:0] OFF_CTRL   = 2'h3;

	// Values after reset.
	localparam logic [7:0] CTRL_RESET  = 8'h9B;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [2:0] MASK_RESET  = 3'h0;
	localparam logic       IRQ_RESET   = 1'h0;

	// Control word fields for a mode definition.
	localparam int MODE_FLAG_BIT = 7;
	localparam int GA_MODE_HI    = 6;
	localparam int GA_MODE_LO    = 5;
	localparam int A_DIR_BIT     = 4;
	localparam int CU_DIR_BIT    = 3;
	localparam int GB_MODE_BIT   = 2;
	localparam int B_DIR_BIT     = 1;
	localparam int CL_DIR_BIT    = 0;

	// Control word fields for a single-bit set/reset command.
	localparam int BSR_SEL_HI  = 3;
	localparam int BSR_SEL_LO  = 1;
	localparam int BSR_VAL_BIT = 0;

	// Port C bit positions that steer the interrupt mask flip-flops.
	localparam logic [2:0] MASK_A_IN_POS  = 3'h4;
	localparam logic [2:0] MASK_A_OUT_POS = 3'h6;
	localparam logic [2:0] MASK_B_POS     = 3'h2;

	// Index of each mask flip-flop in the mask vector.
	localparam int MASK_A_IN  = 0;
	localparam int MASK_A_OUT = 1;
	localparam int MASK_B     = 2;

	// Operating modes of a group.
	typedef enum logic [1:0] {
		MODE_BASIC,
		MODE_STROBED,
		MODE_BIDIR
	} ppio_mode_t;

	// Group A mode from a control word.
	function automatic ppio_mode_t ppio_mode_a(input logic [7:0] cw);
		ppio_mode_t m;
		m = MODE_BASIC;
		if (cw[GA_MODE_HI]) begin
			m = MODE_BIDIR;
		end else if (cw[GA_MODE_LO]) begin
			m = MODE_STROBED;
		end
		return m;
	endfunction : ppio_mode_a

	// Group B mode from a control word.
	function automatic ppio_mode_t ppio_mode_b(input logic [7:0] cw);
		return cw[GB_MODE_BIT] ? MODE_STROBED : MODE_BASIC;
	endfunction : ppio_mode_b

endpackage : ppio_pkg

// ===== src/ppio_bus_if.sv
/*
 * Carrier between the CPU strobe decoder and the register core.
 * Assumes both ends run on the same clock.
 */
interface ppio_bus_if;
	logic       rd_active; // Read strobe qualified by chip select.
	logic       wr_pulse;  // One cycle at the start of a write.
	logic [1:0] sel;       // Register index.
	logic [7:0] wdata;     // Write data.

	modport dec (output rd_active, output wr_pulse, output sel,
		output wdata);
	modport core (input rd_active, input wr_pulse, input sel,
		input wdata);
endinterface : ppio_bus_if

// ===== src/ppio_bus_dec.sv
/*
 * Decoder of the CPU strobes for the parallel I/O core.
 * Assumes the strobes are synchronous to mclk and held for two cycles
 * or more; a write is taken in the first cycle the strobe is seen.
 */
module ppio_bus_dec (
	input  wire logic       mclk,       // System clock.
	input  wire logic       resetn,     // Synchronous reset, active low.
	input  wire logic       cs_n,       // Chip select, active low.
	input  wire logic       rd_n,       // Read strobe, active low.
	input  wire logic       wr_n,       // Write strobe, active low.
	input  wire logic [1:0] sel,        // Port-select lines.
	input  wire logic [7:0] data,       // Data bus input.
	ppio_bus_if.dec         bus         // Decoded access.
);
	import ppio_pkg::*;

	logic wr_seen;
	logic next_wr_seen;
	logic wr_active;

	// A write is only valid with read high; both low is no access.
	assign wr_active = !cs_n && !wr_n && rd_n;

	// Remember the strobe so that a long write loads once.
	always_comb begin
		next_wr_seen = wr_active;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wr_seen <= 1'h0;
		end else begin
			wr_seen <= next_wr_seen;
		end
	end

	// Decoded outputs toward the core.
	assign bus.rd_active = !cs_n && !rd_n && wr_n;
	assign bus.wr_pulse  = wr_active && !wr_seen;
	assign bus.sel       = sel;
	assign bus.wdata     = data;

endmodule : ppio_bus_dec

// ===== testbench/ppio_pins_model.sv
/*
 * Peripheral side of one 8-bit port: resolves the wire level.
 * Assumes the core drives a bit while its enable is low; the
 * peripheral then releases that bit and drives all the others.
 */
module ppio_pins_model (
	input  wire logic [7:0] drv_o,    // Core output latch.
	input  wire logic [7:0] drv_oe_n, // Core drive enable, low drives.
	input  wire logic [7:0] ext_val,  // Level the peripheral presents.
	output logic      [7:0] pin_lvl   // Resolved wire level.
);
	timeunit 1ns;
	timeprecision 1ps;

	// The peripheral only drives bits the core has released.
	always_comb begin
		pin_lvl = (drv_oe_n & ext_val) | (~drv_oe_n & drv_o);
	end
endmodule : ppio_pins_model

// ===== testbench/ppio_core_tb_top.sv
/*
 * Self-checking bench for the parallel I/O core.
 * Assumes strobes synchronous to mclk and held two cycles per write.
 */
module ppio_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ppio_pkg::*;

	logic       mclk, resetn, cs_n, rd_n, wr_n, sel0, sel1, bus_oe_n;
	logic       req_ai, req_ao, req_b, irq_a, irq_b;
	logic [7:0] din, bus_o, pa_o, pa_oe, pb_o, pb_oe, pc_o, pc_oe;
	logic [7:0] pa_l, pb_l, pc_l, ext_a, ext_b, ext_c, cw, la, lb, lc;
	logic [2:0] mask, em;
	int         fail_count, checks_done, seed, i, b;

	// Free-running 100 MHz clock.
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;

	ppio_core u_dut (.mclk(mclk), .resetn(resetn), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .port_select_lsb(sel0),
		.port_select_msb(sel1), .bus_lines_i(din), .bus_lines_o(bus_o),
		.bus_lines_oe_n(bus_oe_n), .first_port_lines_i(pa_l),
		.first_port_lines_o(pa_o), .first_port_lines_oe_n(pa_oe),
		.second_port_lines_i(pb_l), .second_port_lines_o(pb_o),
		.second_port_lines_oe_n(pb_oe), .third_port_lines_i(pc_l),
		.third_port_lines_o(pc_o), .third_port_lines_oe_n(pc_oe),
		.hs_req_a_in(req_ai), .hs_req_a_out(req_ao), .hs_req_b(req_b),
		.irq_a(irq_a), .irq_b(irq_b), .irq_mask_ff(mask));
	ppio_pins_model u_pa (.drv_o(pa_o), .drv_oe_n(pa_oe),
		.ext_val(ext_a), .pin_lvl(pa_l));
	ppio_pins_model u_pb (.drv_o(pb_o), .drv_oe_n(pb_oe),
		.ext_val(ext_b), .pin_lvl(pb_l));
	ppio_pins_model u_pc (.drv_o(pc_o), .drv_oe_n(pc_oe),
		.ext_val(ext_c), .pin_lvl(pc_l));

	// Expected drive enables of a port for a control word.
	function automatic logic [7:0] dir_oe(input logic [7:0] c,
		input int p);
		if (p == 0) begin
			return (c[6] | c[4]) ? 8'hFF : 8'h00;
		end else if (p == 1) begin
			return c[1] ? 8'hFF : 8'h00;
		end
		return {{4{c[3]}}, {4{c[0]}}};
	endfunction : dir_oe

	// Expected wire level from latch, enable and peripheral value.
	function automatic logic [7:0] wire_of(input logic [7:0] l, oe, e);
		return (oe & e) | (~oe & l);
	endfunction : wire_of

	task automatic chk_byte(input logic [7:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, exp);
		chk_byte({7'h0, got}, {7'h0, exp});
	endtask : chk_bit

	// One write cycle, then the expected state follows it.
	task automatic bus_wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge mclk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		{sel1, sel0} <= s;
		din <= d;
		repeat (2) @(posedge mclk);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		@(posedge mclk);
		if (s == 2'h3 && d[7]) begin
			cw = d;
			{la, lb, lc} = 24'h0;
			em = 3'h0;
		end else if (s == 2'h3) begin
			lc[d[3:1]] = d[0];
			if (cw[6:5] != 2'h0 && d[3:1] == 3'h4) em[0] = d[0];
			if (cw[6:5] != 2'h0 && d[3:1] == 3'h6) em[1] = d[0];
			if (cw[2] && d[3:1] == 3'h2) em[2] = d[0];
		end else if (s == 2'h0) la = d;
		else if (s == 2'h1) lb = d;
		else lc = d;
	endtask : bus_wr

	// One read cycle with the bus drive checked once after the strobe starts and once after it ends.
	task automatic bus_rd(input logic [1:0] s, input logic [7:0] exp);
		@(posedge mclk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		{sel1, sel0} <= s;
		@(negedge mclk);
		chk_bit(bus_oe_n, 1'b0);
		@(posedge mclk);
		@(negedge mclk);
		chk_byte(bus_o, exp);
		@(posedge mclk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		@(negedge mclk);
		chk_bit(bus_oe_n, 1'b1);
	endtask : bus_rd

	// Compares every port, mask and register against the expectation.
	task automatic check_all;
		@(negedge mclk);
		chk_byte(pa_oe, dir_oe(cw, 0));
		chk_byte(pb_oe, dir_oe(cw, 1));
		chk_byte(pc_oe, dir_oe(cw, 2));
		chk_byte(pa_o, la);
		chk_byte(pb_o, lb);
		chk_byte(pc_o, lc);
		chk_byte({5'h0, mask}, {5'h0, em});
		bus_rd(2'h0, wire_of(la, dir_oe(cw, 0), ext_a));
		bus_rd(2'h1, wire_of(lb, dir_oe(cw, 1), ext_b));
		bus_rd(2'h2, wire_of(lc, dir_oe(cw, 2), ext_c));
		bus_rd(2'h3, cw | 8'h80);
	endtask : check_all

	task automatic wait_irq(input logic ea, eb);
		for (int k = 0; k < 4 && !(irq_a === ea && irq_b === eb); k++)
			@(posedge mclk);
		@(negedge mclk);
		chk_bit(irq_a, ea);
		chk_bit(irq_b, eb);
	endtask : wait_irq

	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		seed = 32'h9373;
		{fail_count, checks_done} = 0;
		{cs_n, rd_n, wr_n, resetn, sel0, sel1} = 6'h38;
		{req_ai, req_ao, req_b, din} = 11'h0;
		ext_a = $random(seed);
		ext_b = $random(seed);
		ext_c = $random(seed);
		{cw, la, lb, lc, em} = {8'h9B, 27'h0};
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		check_all();
		// Random basic-mode directions with random data and pins.
		for (i = 0; i < 24; i++) begin
			bus_wr(2'h3, (i == 0) ? 8'h80 :
				8'h80 | 8'($random(seed) & 8'h1B));
			ext_a <= $random(seed);
			ext_b <= $random(seed);
			ext_c <= $random(seed);
			bus_wr(2'h0, $random(seed));
			bus_wr(2'h1, $random(seed));
			bus_wr(2'h2, $random(seed));
			check_all();
		end
		// Set and clear each port C bit alone.
		bus_wr(2'h3, 8'h80);
		bus_wr(2'h2, $random(seed));
		for (b = 0; b < 16; b++) begin
			bus_wr(2'h3, {4'h0, b[3:1], ~b[0]});
			@(negedge mclk);
			chk_byte(pc_o, lc);
		end
		bus_rd(2'h3, 8'h80);
		// Both strobes low: no write and no bus drive.
		@(posedge mclk);
		{cs_n, rd_n, wr_n} <= 3'h0;
		{sel1, sel0} <= 2'h0;
		din <= 8'hA5;
		@(negedge mclk);
		chk_bit(bus_oe_n, 1'b1);
		@(posedge mclk);
		{cs_n, rd_n, wr_n} <= 3'h7;
		@(negedge mclk);
		chk_byte(pa_o, la);
		// Strobed groups: masks through set/reset, gating of requests.
		bus_wr(2'h3, 8'hA4);
		bus_wr(2'h3, 8'h09);
		bus_wr(2'h3, 8'h05);
		@(negedge mclk);
		chk_byte({5'h0, mask}, {5'h0, em});
		chk_byte(pc_o, lc);
		@(posedge mclk);
		req_ai <= 1'b1;
		req_b <= 1'b1;
		wait_irq(1'b1, 1'b1);
		bus_wr(2'h3, 8'h08);
		wait_irq(1'b0, 1'b1);
		bus_wr(2'h3, 8'h0D);
		req_ao <= 1'b1;
		wait_irq(1'b1, 1'b1);
		// A new mode definition clears masks, latches and interrupts.
		bus_wr(2'h3, 8'hC0);
		wait_irq(1'b0, 1'b0);
		{req_ai, req_ao, req_b} <= 3'h0;
		check_all();
		wrap_up();
	end
endmodule : ppio_core_tb_top
